/* File: vbus_path_regs.svh */
// timing counts, reset values and window constants of the bus power path control
`ifndef VBUS_PATH_REGS_SVH
`define VBUS_PATH_REGS_SVH

// ----------------------------------------------------------------------------
// clock and time base
// ----------------------------------------------------------------------------
`define REF_CLK_HZ            250000000
`define MS_PER_S              1000
`define MS_TICK_CYCLES        (`REF_CLK_HZ / `MS_PER_S)

// ----------------------------------------------------------------------------
// durations in milliseconds; transition and zero time are reset values before the nvm reload, fault recovery is fixed
// ----------------------------------------------------------------------------
`define PROFILE_TRANSITION_MS 10'd280
`define ZERO_V_TIME_MS        10'd100
`define FAULT_RECOVERY_MS     10'd30

// ----------------------------------------------------------------------------
// valid window, in percent of the nominal voltage
// ----------------------------------------------------------------------------
`define PCT_SCALE             17'd100
`define WINDOW_BASE_PCT       17'd5
`define SHIFT_RST             4'h0

// ----------------------------------------------------------------------------
// check enables before the nvm reload
// ----------------------------------------------------------------------------
`define UVLO_EN_RST           1'b0
`define OVLO_EN_RST           1'b0
`define WINDOW_EN_RST         1'b1
`define DISCHARGE_EN_RST      1'b1

`endif

/* File: vbus_path_pkg.sv */
// types shared by the bus power path control
package vbus_path_pkg;

   // ----------------------------------------------------------------------------
   // attach state reported by the type-c state machine
   // ----------------------------------------------------------------------------
   typedef enum logic [2:0] {
      unattached_state,
      attach_wait_state,
      attached_as_source,
      debug_acc_unoriented_state,
      debug_acc_oriented_state,
      audio_acc_state,
      other_state
   } typec_state_e;

   // ----------------------------------------------------------------------------
   // power path sequencer states
   // ----------------------------------------------------------------------------
   typedef enum {
      pp_idle,
      pp_attach_check,
      pp_settle,
      pp_on,
      pp_fault,
      pp_detach_discharge
   } pp_state_e;

   // ----------------------------------------------------------------------------
   // nonvolatile defaults, presented by the nvm shadow
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic [3:0] hi_shift;
      logic [3:0] lo_shift;
      logic [9:0] transition_ms;
      logic [9:0] zero_ms;
      logic       uvlo_en;
      logic       ovlo_en;
      logic       window_en;
      logic       discharge_en;
   } nvm_cfg_s;

   // ----------------------------------------------------------------------------
   // runtime values written by software
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic [3:0] hi_shift;
      logic [3:0] lo_shift;
      logic [9:0] transition_ms;
      logic [9:0] zero_ms;
      logic       uvlo_en;
      logic       ovlo_en;
   } sw_cfg_s;

endpackage : vbus_path_pkg

/* File: interval_timer.sv */
// millisecond interval timer with its own divider from the reference clock
`include "vbus_path_regs.svh"

module interval_timer #(
   parameter int unsigned MS_CYCLES = `MS_TICK_CYCLES
) (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   // control
   input  wire logic       start,
   input  wire logic [9:0] duration_ms,
   // status
   output logic            busy,
   output logic            done
);

   logic [17:0] div_cnt;
   logic [17:0] next_div_cnt;
   logic [9:0]  ms_left;
   logic [9:0]  next_ms_left;
   logic        next_busy;
   logic        next_done;
   logic        tick;

   // ----------------------------------------------------------------------------
   // next state: a new start restarts both divider and count
   // ----------------------------------------------------------------------------
   always_comb begin
      tick         = (div_cnt == 18'(MS_CYCLES - 1));
      next_div_cnt = tick ? 18'h0 : div_cnt + 18'h1;
      next_ms_left = ms_left;
      next_busy    = busy;
      next_done    = 1'b0;
      if (start) begin
         next_div_cnt = 18'h0;
         // a zero length still lasts one tick so the caller sees done
         next_ms_left = (duration_ms == 10'h0) ? 10'h1 : duration_ms;
         next_busy    = 1'b1;
      end else if (busy && tick) begin
         next_ms_left = ms_left - 10'h1;
         if (ms_left == 10'h1) begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end
      end
      if (!busy && !start) begin
         next_div_cnt = 18'h0;                       // divider idles between intervals
      end
   end

   // ----------------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         div_cnt <= 18'h0;
         ms_left <= 10'h0;
         busy    <= 1'b0;
         done    <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         ms_left <= next_ms_left;
         busy    <= next_busy;
         done    <= next_done;
      end
   end

endmodule : interval_timer

/* File: vbus_power_path_control.sv */
// bus voltage supervision, power path enable and discharge sequencing
`include "vbus_path_regs.svh"

module vbus_power_path_control #(
   parameter int unsigned MS_CYCLES = `MS_TICK_CYCLES
) (
   // clock and reset
   input  wire logic                       ref_clk,
   input  wire logic                       sys_rst,
   // type-c state machine
   input  wire vbus_path_pkg::typec_state_e typec_state,
   // measurements, 50 mV per code
   input  wire logic [9:0]                 bus_voltage_sense_in,
   input  wire logic [9:0]                 supply_voltage_in,
   // analog comparators
   input  wire logic                       supply_above_uvlo,
   input  wire logic                       supply_below_ovlo,
   input  wire logic                       bus_above_uvlo,
   // profile selection
   input  wire logic                       profile_change,
   input  wire logic [9:0]                 profile_nominal,
   // nonvolatile defaults
   input  wire vbus_path_pkg::nvm_cfg_s    nvm_cfg,
   // software writes
   input  wire logic                       sw_threshold_wr,
   input  wire logic                       sw_timing_wr,
   input  wire logic                       sw_check_wr,
   input  wire vbus_path_pkg::sw_cfg_s     sw_cfg,
   // open-drain enable pin, oe high pulls the pin low
   output logic                            source_power_enable_n_out,
   output logic                            source_power_enable_n_oe,
   // discharge paths
   output logic                            discharge_int_en,
   output logic                            discharge_ext_en,
   // to the type-c state machine
   output logic                            cc_term_remove,
   output logic                            fault_recovery_state,
   output logic                            recovery_done,
   output logic                            connection_blocked,
   // status
   output logic                            power_enable_status,
   output logic                            monitor_masked,
   output logic                            window_ok,
   output logic [9:0]                      nominal_target
);

   // ----------------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------------
   vbus_path_pkg::pp_state_e state;
   vbus_path_pkg::pp_state_e next_state;

   logic       reload;
   logic       next_reload;
   logic [3:0] hi_shift;
   logic [3:0] next_hi_shift;
   logic [3:0] lo_shift;
   logic [3:0] next_lo_shift;
   logic [9:0] transition_ms;
   logic [9:0] next_transition_ms;
   logic [9:0] zero_ms;
   logic [9:0] next_zero_ms;
   logic       uvlo_en;
   logic       next_uvlo_en;
   logic       ovlo_en;
   logic       next_ovlo_en;
   logic       window_en;
   logic       next_window_en;
   logic       discharge_en;
   logic       next_discharge_en;

   logic [9:0] next_nominal_target;
   logic       lowering;
   logic       next_lowering;
   logic       next_enable_oe;
   logic       next_discharge;
   logic       next_cc_term_remove;
   logic       next_fault_state;
   logic       next_recovery_done;
   logic       next_blocked;
   logic       next_masked;
   logic       next_window_ok;

   logic       attached;
   logic       supply_ok;
   logic       bus_ok;
   logic [9:0] mon_code;
   logic [16:0] mon_x100;
   logic [16:0] high_limit;
   logic [16:0] low_limit;
   logic       in_window;

   logic       timer_start;
   logic [9:0] timer_len;
   logic       timer_done;

   // ----------------------------------------------------------------------------
   // interval timer shared by transition, discharge and recovery
   // ----------------------------------------------------------------------------
   interval_timer #(
      .MS_CYCLES   (MS_CYCLES)
   ) u_timer (
      .ref_clk     (ref_clk),
      .sys_rst     (sys_rst),
      .start       (timer_start),
      .duration_ms (timer_len),
      .busy        (),
      .done        (timer_done)
   );

   // ----------------------------------------------------------------------------
   // configuration: nvm reload after reset, runtime software writes
   // ----------------------------------------------------------------------------
   always_comb begin
      next_reload        = 1'b0;
      next_hi_shift      = hi_shift;
      next_lo_shift      = lo_shift;
      next_transition_ms = transition_ms;
      next_zero_ms       = zero_ms;
      next_uvlo_en       = uvlo_en;
      next_ovlo_en       = ovlo_en;
      next_window_en     = window_en;
      next_discharge_en  = discharge_en;
      if (reload) begin
         // first cycle after reset takes every default from the nvm shadow
         next_hi_shift      = nvm_cfg.hi_shift;
         next_lo_shift      = nvm_cfg.lo_shift;
         next_transition_ms = nvm_cfg.transition_ms;
         next_zero_ms       = nvm_cfg.zero_ms;
         next_uvlo_en       = nvm_cfg.uvlo_en;
         next_ovlo_en       = nvm_cfg.ovlo_en;
         next_window_en     = nvm_cfg.window_en;
         next_discharge_en  = nvm_cfg.discharge_en;
      end else begin
         // thresholds only follow software while the port is attached
         if (sw_threshold_wr && attached) begin
            next_hi_shift = sw_cfg.hi_shift;
            next_lo_shift = sw_cfg.lo_shift;
         end
         if (sw_timing_wr) begin
            next_transition_ms = sw_cfg.transition_ms;
            next_zero_ms       = sw_cfg.zero_ms;
         end
         if (sw_check_wr) begin
            next_uvlo_en = sw_cfg.uvlo_en;
            next_ovlo_en = sw_cfg.ovlo_en;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         reload        <= 1'b1;
         hi_shift      <= `SHIFT_RST;
         lo_shift      <= `SHIFT_RST;
         transition_ms <= `PROFILE_TRANSITION_MS;
         zero_ms       <= `ZERO_V_TIME_MS;
         uvlo_en       <= `UVLO_EN_RST;
         ovlo_en       <= `OVLO_EN_RST;
         window_en     <= `WINDOW_EN_RST;
         discharge_en  <= `DISCHARGE_EN_RST;
      end else begin
         reload        <= next_reload;
         hi_shift      <= next_hi_shift;
         lo_shift      <= next_lo_shift;
         transition_ms <= next_transition_ms;
         zero_ms       <= next_zero_ms;
         uvlo_en       <= next_uvlo_en;
         ovlo_en       <= next_ovlo_en;
         window_en     <= next_window_en;
         discharge_en  <= next_discharge_en;
      end
   end

   // ----------------------------------------------------------------------------
   // condition checks
   // ----------------------------------------------------------------------------
   // multiply instead of divide: compare v*100 against nominal*(100 +/- pct)
   always_comb begin
      attached   = (typec_state == vbus_path_pkg::attached_as_source) ||
                   (typec_state == vbus_path_pkg::debug_acc_unoriented_state) ||
                   (typec_state == vbus_path_pkg::debug_acc_oriented_state);
      supply_ok  = (!uvlo_en || supply_above_uvlo) &&
                   (!ovlo_en || supply_below_ovlo);
      mon_code   = source_power_enable_n_oe ? bus_voltage_sense_in
                                            : supply_voltage_in;
      mon_x100   = 17'(mon_code) * `PCT_SCALE;
      high_limit = 17'(nominal_target) *
                   (`PCT_SCALE + `WINDOW_BASE_PCT + 17'(hi_shift));
      low_limit  = 17'(nominal_target) *
                   (`PCT_SCALE - `WINDOW_BASE_PCT - 17'(lo_shift));
      in_window  = (mon_x100 <= high_limit) && (mon_x100 >= low_limit);
      bus_ok     = window_en ? in_window : bus_above_uvlo;
   end

   // ----------------------------------------------------------------------------
   // power path sequencer
   // ----------------------------------------------------------------------------
   always_comb begin
      next_state          = state;
      next_nominal_target = nominal_target;
      next_lowering       = lowering;
      next_recovery_done  = 1'b0;
      timer_start         = 1'b0;
      timer_len           = transition_ms;
      case (state)
         vbus_path_pkg::pp_idle: begin
            if (attached && !reload) begin
               next_nominal_target = profile_nominal;
               next_lowering       = 1'b0;
               next_state          = vbus_path_pkg::pp_attach_check;
            end
         end
         vbus_path_pkg::pp_attach_check: begin
            // enable waits here, held off, while any check fails
            if (!attached) begin
               timer_start = 1'b1;
               timer_len   = zero_ms;
               next_state  = vbus_path_pkg::pp_detach_discharge;
            end else if (supply_ok && bus_ok) begin
               timer_start = 1'b1;
               next_state  = vbus_path_pkg::pp_settle;
            end
         end
         vbus_path_pkg::pp_settle, vbus_path_pkg::pp_on: begin
            if (!attached) begin
               timer_start = 1'b1;
               timer_len   = zero_ms;
               next_state  = vbus_path_pkg::pp_detach_discharge;
            end else if (!supply_ok ||
                         (state == vbus_path_pkg::pp_on && !bus_ok)) begin
               timer_start = 1'b1;
               timer_len   = `FAULT_RECOVERY_MS;
               next_state  = vbus_path_pkg::pp_fault;
            end else if (profile_change) begin
               // a new profile restarts the mask even mid transition
               next_nominal_target = profile_nominal;
               next_lowering       = (profile_nominal < nominal_target);
               timer_start         = 1'b1;
               next_state          = vbus_path_pkg::pp_settle;
            end else if (state == vbus_path_pkg::pp_settle && timer_done) begin
               next_lowering = 1'b0;
               next_state    = vbus_path_pkg::pp_on;
            end
         end
         vbus_path_pkg::pp_fault: begin
            if (timer_done) begin
               next_recovery_done = 1'b1;
               next_state         = vbus_path_pkg::pp_idle;
            end
         end
         vbus_path_pkg::pp_detach_discharge: begin
            // discharge runs to its end even if a partner returns meanwhile
            if (timer_done) begin
               next_state = vbus_path_pkg::pp_idle;
            end
         end
         default: begin
            next_state = vbus_path_pkg::pp_idle;
         end
      endcase
   end

   // ----------------------------------------------------------------------------
   // registered outputs, decoded from the next state; window_ok from the current supply and bus checks
   // ----------------------------------------------------------------------------
   always_comb begin
      next_enable_oe = (next_state == vbus_path_pkg::pp_settle) ||
                       (next_state == vbus_path_pkg::pp_on);
      next_discharge = discharge_en &&
                       ((next_state == vbus_path_pkg::pp_detach_discharge) ||
                        (next_state == vbus_path_pkg::pp_fault) ||
                        (next_state == vbus_path_pkg::pp_settle &&
                         next_lowering));
      next_cc_term_remove = (next_state == vbus_path_pkg::pp_fault);
      next_fault_state    = (next_state == vbus_path_pkg::pp_fault);
      next_blocked        = (next_state == vbus_path_pkg::pp_attach_check);
      next_masked         = (next_state == vbus_path_pkg::pp_settle);
      next_window_ok      = supply_ok && bus_ok;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state                     <= vbus_path_pkg::pp_idle;
         nominal_target            <= 10'h0;
         lowering                  <= 1'b0;
         source_power_enable_n_out <= 1'b0;     // open drain: only ever pulls low
         source_power_enable_n_oe  <= 1'b0;
         power_enable_status       <= 1'b0;
         discharge_int_en          <= 1'b0;
         discharge_ext_en          <= 1'b0;
         cc_term_remove            <= 1'b0;
         fault_recovery_state      <= 1'b0;
         recovery_done             <= 1'b0;
         connection_blocked        <= 1'b0;
         monitor_masked            <= 1'b0;
         window_ok                 <= 1'b0;
      end else begin
         state                     <= next_state;
         nominal_target            <= next_nominal_target;
         lowering                  <= next_lowering;
         source_power_enable_n_out <= 1'b0;
         source_power_enable_n_oe  <= next_enable_oe;
         power_enable_status       <= next_enable_oe;
         discharge_int_en          <= next_discharge;
         discharge_ext_en          <= next_discharge;
         cc_term_remove            <= next_cc_term_remove;
         fault_recovery_state      <= next_fault_state;
         recovery_done             <= next_recovery_done;
         connection_blocked        <= next_blocked;
         monitor_masked            <= next_masked;
         window_ok                 <= next_window_ok;
      end
   end

endmodule : vbus_power_path_control

/* File: vbus_path_asserts.sv */
// port assertions of the bus power path control
module vbus_path_asserts #(
   parameter int unsigned MS_CYCLES = 4
) (
   // clock, reset and inputs
   input wire logic                        ref_clk,
   input wire logic                        sys_rst,
   input wire vbus_path_pkg::typec_state_e typec_state,
   input wire logic                        profile_change,
   input wire logic [9:0]                  profile_nominal,
   input wire vbus_path_pkg::nvm_cfg_s     nvm_cfg,
   // outputs
   input wire logic                        source_power_enable_n_out,
   input wire logic                        source_power_enable_n_oe,
   input wire logic                        discharge_int_en,
   input wire logic                        discharge_ext_en,
   input wire logic                        cc_term_remove,
   input wire logic                        fault_recovery_state,
   input wire logic                        recovery_done,
   input wire logic                        connection_blocked,
   input wire logic                        power_enable_status,
   input wire logic                        monitor_masked,
   input wire logic [9:0]                  nominal_target
);
   // 30 ms recovery plus slack
   localparam int REC = 30 * MS_CYCLES + 8;
   logic att;
   assign att = typec_state inside {[vbus_path_pkg::attached_as_source:
      vbus_path_pkg::debug_acc_oriented_state]};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // fault recovery steps
   sequence s_fault_held;
      !source_power_enable_n_oe && cc_term_remove && (discharge_int_en || !nvm_cfg.discharge_en);
   endsequence
   sequence s_fault_end;
      ##[1:REC] recovery_done ##1 (!fault_recovery_state && !cc_term_remove);
   endsequence
   a_pin_value: assert property (source_power_enable_n_out == 1'b0)
      else $error("pin high");
   a_attach_gate: assert property (!att |=> !source_power_enable_n_oe)
      else $error("enable unattached");
   a_status_mirror: assert property (power_enable_status == source_power_enable_n_oe)
      else $error("status mismatch");
   a_blocked_off: assert property (connection_blocked |-> !source_power_enable_n_oe)
      else $error("enable while blocked");
   a_rise_masked: assert property ($rose(source_power_enable_n_oe) |-> monitor_masked && $past(att))
      else $error("bad enable rise");
   a_fault_entry: assert property ($rose(fault_recovery_state) |-> s_fault_held)
      else $error("bad fault entry");
   a_fault_exit: assert property ($rose(fault_recovery_state) |-> s_fault_end)
      else $error("recovery hung");
   a_disch_pair: assert property (discharge_int_en == discharge_ext_en)
      else $error("discharge paths differ");
   a_detach_disch: assert property (source_power_enable_n_oe && !att && nvm_cfg.discharge_en
      |=> !source_power_enable_n_oe && discharge_int_en)
      else $error("detach without discharge");
   a_lower_profile: assert property (profile_change && att && source_power_enable_n_oe &&
      nvm_cfg.discharge_en && profile_nominal < nominal_target |=> monitor_masked &&
      discharge_int_en && nominal_target == $past(profile_nominal))
      else $error("lower profile unhandled");
endmodule : vbus_path_asserts

/* File: vbus_source_model.sv */
// external switch and bus source model
module vbus_source_model (
   // from the design
   input  wire logic       en_n_out,
   input  wire logic       en_n_oe,
   input  wire logic       discharge,
   // from the bench
   input  wire logic [9:0] src_level,
   // pin and sensed bus
   output logic            pin_level,
   output logic [9:0]      bus_level
);
   // pull-up unless driven
   assign pin_level = en_n_oe ? en_n_out : 1'b1;
   // open switch: residual level, no held value
   assign bus_level = !pin_level ? src_level : (discharge ? 10'h000 : 10'h014);
endmodule : vbus_source_model

/* File: tb.sv */
// bench of the bus power path control
module tb;
   timeunit 1ns;
   timeprecision 100ps;
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; $display("Error %0t: got %h expected %h", $time, a, b); end end
`define WAITC(c, n) for (int k = 0; !(c); k++) begin if (k == (n)) begin failures++; end_of_test(); end step(1); end
   localparam int unsigned MS_CYCLES = 4;
   logic ref_clk = 1'b0, sys_rst = 1'b1;
   vbus_path_pkg::typec_state_e typec_state;
   vbus_path_pkg::nvm_cfg_s nvm_cfg;
   vbus_path_pkg::sw_cfg_s sw_cfg;
   logic [9:0] supply_voltage_in, bus_voltage_sense_in, profile_nominal, src_level, nominal_target;
   logic supply_above_uvlo, supply_below_ovlo, bus_above_uvlo, profile_change, pin_level;
   logic sw_threshold_wr, sw_timing_wr, sw_check_wr, source_power_enable_n_out;
   logic source_power_enable_n_oe, discharge_int_en, discharge_ext_en, cc_term_remove;
   logic fault_recovery_state, recovery_done, connection_blocked, power_enable_status;
   logic monitor_masked, window_ok;
   int failures = 0, compares = 0, hi = 2, lo = 3, n, m;
   int exp_nom[$];
   always #2 ref_clk = ~ref_clk;
   vbus_power_path_control #(.MS_CYCLES(MS_CYCLES)) i_dut (.ref_clk, .sys_rst, .typec_state,
      .bus_voltage_sense_in, .supply_voltage_in, .supply_above_uvlo, .supply_below_ovlo,
      .bus_above_uvlo, .profile_change, .profile_nominal, .nvm_cfg, .sw_threshold_wr,
      .sw_timing_wr, .sw_check_wr, .sw_cfg, .source_power_enable_n_out, .source_power_enable_n_oe,
      .discharge_int_en, .discharge_ext_en, .cc_term_remove, .fault_recovery_state, .recovery_done,
      .connection_blocked, .power_enable_status, .monitor_masked, .window_ok, .nominal_target);
   vbus_source_model i_src (.en_n_out(source_power_enable_n_out), .en_n_oe(source_power_enable_n_oe),
      .discharge(discharge_int_en), .src_level, .pin_level, .bus_level(bus_voltage_sense_in));
   // window model, percent
   function automatic bit in_win(int v, int nm, int l, int h);
      return v * 100 >= nm * (95 - l) && v * 100 <= nm * (105 + h);
   endfunction : in_win
   task automatic step(int c);
      repeat (c) @(posedge ref_clk);
      #1;
   endtask : step
   task automatic end_of_test();
      if (failures == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_of_test
   initial begin
      void'($urandom(32'h34ccf573));
      typec_state = vbus_path_pkg::unattached_state;
      {supply_voltage_in, src_level, sw_cfg} = '0;
      {supply_above_uvlo, supply_below_ovlo, bus_above_uvlo} = 3'h7;
      {profile_change, sw_threshold_wr, sw_timing_wr, sw_check_wr} = 4'h0;
      nvm_cfg = '{4'h2, 4'h3, 10'h002, 10'h001, 1'b1, 1'b1, 1'b1, 1'b1};
      n = 100 + $urandom % 300;
      profile_nominal = 10'(n);
      step(3);
      sys_rst = 1'b0;
      `CHK({source_power_enable_n_oe, discharge_int_en, fault_recovery_state}, 3'h0)
      step(2);
      // supply locked out, then over the limit
      supply_above_uvlo = 1'b0;
      supply_voltage_in = 10'(n);
      typec_state = vbus_path_pkg::attached_as_source;
      exp_nom.push_back(n);
      step(12);
      `CHK(source_power_enable_n_oe, 1'b0)
      `CHK(connection_blocked, 1'b1)
      supply_above_uvlo = 1'b1;
      supply_voltage_in = 10'(n * (105 + hi) / 100 + 1);
      step(6);
      `CHK(source_power_enable_n_oe, in_win(supply_voltage_in, n, lo, hi))
      supply_voltage_in = 10'(n * (105 + hi) / 100);
      src_level = supply_voltage_in;
      `WAITC(source_power_enable_n_oe, 20)
      `CHK(monitor_masked, 1'b1)
      `CHK(nominal_target, 10'(exp_nom[$]))
      `CHK(pin_level, 1'b0)
      // path on: bus sense decides
      supply_voltage_in = 10'h000;
      step(4);
      `CHK(source_power_enable_n_oe, in_win(src_level, n, lo, hi))
      `WAITC(!monitor_masked, 40)
      m = n - 20;
      profile_nominal = 10'(m);
      profile_change = 1'b1;
      exp_nom.push_back(m);
      step(1);
      profile_change = 1'b0;
      src_level = 10'(m);
      `CHK(discharge_int_en, 1'b1)
      `CHK(nominal_target, 10'(exp_nom[$]))
      `WAITC(!monitor_masked, 40)
      `CHK(discharge_int_en, 1'b0)
      // widest high limit, then beyond
      hi = 15;
      sw_cfg.hi_shift = 4'hf;
      sw_cfg.lo_shift = 4'(lo);
      sw_threshold_wr = 1'b1;
      step(1);
      sw_threshold_wr = 1'b0;
      src_level = 10'(m * 120 / 100);
      step(4);
      `CHK(window_ok, in_win(src_level, m, lo, hi))
      `CHK(source_power_enable_n_oe, 1'b1)
      src_level = 10'(m * 120 / 100 + 1);
      step(2);
      `CHK(source_power_enable_n_oe, in_win(src_level, m, lo, hi))
      `CHK(fault_recovery_state, 1'b1)
      `CHK(discharge_int_en, 1'b1)
      typec_state = vbus_path_pkg::unattached_state;
      `WAITC(recovery_done, 140)
      step(1);
      `CHK(cc_term_remove, 1'b0)
      // software clears the uvlo and ovlo checks, shortens the transition time, lengthens the zero time
      sw_cfg.uvlo_en = 1'b0;
      sw_cfg.ovlo_en = 1'b0;
      sw_cfg.transition_ms = 10'h001;
      sw_cfg.zero_ms = 10'h002;
      {sw_check_wr, sw_timing_wr, supply_above_uvlo} = 3'h6;
      step(1);
      {sw_check_wr, sw_timing_wr} = 2'h0;
      {supply_voltage_in, src_level} = {10'(m), 10'(m)};
      `WAITC(!discharge_int_en, 40)
      for (int i = 0; i < 2; i++) begin
         typec_state = vbus_path_pkg::typec_state_e'(3 + i);
         `WAITC(source_power_enable_n_oe, 20)
         `CHK(connection_blocked, 1'b0)
         `WAITC(!monitor_masked, 9)
         typec_state = vbus_path_pkg::unattached_state;
         step(2);
         `CHK(discharge_int_en, 1'b1)
         `WAITC(!discharge_int_en, 14)
      end
      typec_state = vbus_path_pkg::audio_acc_state;
      step(10);
      `CHK(source_power_enable_n_oe, 1'b0)
      end_of_test();
   end
endmodule : tb
bind vbus_power_path_control vbus_path_asserts #(.MS_CYCLES(MS_CYCLES)) i_chk (.ref_clk, .sys_rst,
   .typec_state, .profile_change, .profile_nominal, .nvm_cfg, .source_power_enable_n_out,
   .source_power_enable_n_oe, .discharge_int_en, .discharge_ext_en, .cc_term_remove,
   .fault_recovery_state, .recovery_done, .connection_blocked, .power_enable_status,
   .monitor_masked, .nominal_target);
